// *** design/atc_params.svh ***
// register map, field positions, reset values and sync timing of the tick counter
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define ATC_IDX_DIVIDER_CONTROL 4'h0
`define ATC_IDX_SYNC_STATUS     4'h1
`define ATC_IDX_IRQ_LEVEL_CTRL  4'h2
`define ATC_IDX_IRQ_FLAG_BITS   4'h3
`define ATC_IDX_BYTE_STAGE      4'h4
`define ATC_IDX_COUNT_LOW       4'h8
`define ATC_IDX_COUNT_HIGH      4'h9
`define ATC_IDX_TOP_LOW         4'ha
`define ATC_IDX_TOP_HIGH        4'hb
`define ATC_IDX_MATCH_LOW       4'hc
`define ATC_IDX_MATCH_HIGH      4'hd

// field positions
`define ATC_DIV_MSB        2
`define ATC_MATCH_LVL_MSB  3
`define ATC_MATCH_LVL_LSB  2
`define ATC_WRAP_LVL_MSB   1
`define ATC_WRAP_LVL_LSB   0
`define ATC_MATCH_FLAG_BIT 1
`define ATC_WRAP_FLAG_BIT  0
`define ATC_PENDING_BIT    0

// reset values
`define ATC_TOP_RESET   16'hffff
`define ATC_MATCH_RESET 16'h0000
`define ATC_COUNT_RESET 16'h0000
`define ATC_BYTE_RESET  8'h00

// documented widths
`define ATC_COUNT_WIDTH 16
`define ATC_PRE_WIDTH   10

// reference edges between a register update and its effect
`define ATC_SYNC_REF_EDGES 2

`endif

// *** design/atc_pkg.sv ***
// types shared by the tick counter modules
package atc_pkg;

    typedef enum logic [2:0] {
        ATC_DIV_OFF  = 3'h0,
        ATC_DIV_1    = 3'h1,
        ATC_DIV_2    = 3'h2,
        ATC_DIV_8    = 3'h3,
        ATC_DIV_16   = 3'h4,
        ATC_DIV_64   = 3'h5,
        ATC_DIV_256  = 3'h6,
        ATC_DIV_1024 = 3'h7
    } atc_div_t;

    typedef enum logic [1:0] {
        ATC_SYNC_IDLE  = 2'h0,
        ATC_SYNC_WAIT0 = 2'h1,
        ATC_SYNC_WAIT1 = 2'h2
    } atc_sync_t;

    typedef struct packed {
        logic [15:0] count;
        logic [9:0]  pre;
        logic [1:0]  match_dec;
        logic [1:0]  wrap_dec;
        logic        match_hit;
        logic        wrap_hit;
        logic        match_event;
        logic        wrap_event;
    } atc_core_state_t;

    typedef struct packed {
        logic        ref_q;
        atc_sync_t   sync;
        atc_div_t    div_stage;
        atc_div_t    div_act;
        logic [15:0] top_stage;
        logic [15:0] top_act;
        logic [15:0] match_stage;
        logic [15:0] match_act;
        logic [15:0] count_stage;
        logic        count_wr;
        logic [3:0]  lvl;
        logic [1:0]  flags;
        logic [7:0]  stage;
        logic        dp_write;
        logic [3:0]  dp_idx;
        logic        dp_mapped;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        match_irq;
        logic        wrap_irq;
    } atc_top_state_t;

endpackage

// *** design/atc_core.sv ***
// prescaler, 16-bit counter, compare and wrap detection, event thinning
`timescale 1ns/1ns
`default_nettype none
`include "atc_params.svh"

module atc_core
#(
    parameter int PRE_W = `ATC_PRE_WIDTH,
    parameter int CNT_W = `ATC_COUNT_WIDTH
)
(
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             ref_rise,
    input  wire atc_pkg::atc_div_t div_code,
    input  wire logic [CNT_W-1:0] top,
    input  wire logic [CNT_W-1:0] match,
    input  wire logic             load_en,
    input  wire logic [CNT_W-1:0] load_val,
    output logic      [CNT_W-1:0] count,
    output logic                  match_hit,
    output logic                  wrap_hit,
    output logic                  match_event,
    output logic                  wrap_event
);
    import atc_pkg::*;

    if (PRE_W != `ATC_PRE_WIDTH || CNT_W != `ATC_COUNT_WIDTH)
    begin : g_bad_width
        $error("atc_core supports only a 10-bit prescaler and a 16-bit counter");
    end

    function automatic logic [9:0] div_mask(input atc_div_t code);
        case (code)
            ATC_DIV_2:    div_mask = 10'h001;
            ATC_DIV_8:    div_mask = 10'h007;
            ATC_DIV_16:   div_mask = 10'h00f;
            ATC_DIV_64:   div_mask = 10'h03f;
            ATC_DIV_256:  div_mask = 10'h0ff;
            ATC_DIV_1024: div_mask = 10'h3ff;
            default:      div_mask = 10'h000;
        endcase
    endfunction

    // returns {event, next decimation count}; tiny tops thin the events
    function automatic logic [2:0] ev_step(input logic [1:0] dec, input logic [15:0] t);
        logic [1:0] last;
        last = (t == 16'h0000) ? 2'h2 : ((t == 16'h0001) ? 2'h1 : 2'h0);
        if (dec >= last)
            ev_step = {1'b1, 2'h0};
        else
            ev_step = {1'b0, dec + 2'h1};
    endfunction

    atc_core_state_t s_q;
    atc_core_state_t s_d;
    logic            tick;
    logic [2:0]      mstep;
    logic [2:0]      wstep;

    always_comb
    begin
        s_d = s_q;
        s_d.match_hit = 1'b0;
        s_d.wrap_hit = 1'b0;
        s_d.match_event = 1'b0;
        s_d.wrap_event = 1'b0;
        tick = 1'b0;
        mstep = ev_step(s_q.match_dec, top);
        wstep = ev_step(s_q.wrap_dec, top);
        // no gating by any sleep state: the counter keeps running (see [R16])
        if (ref_rise)
        begin
            s_d.pre = s_q.pre + 10'h001; // see [R2]
            tick = (div_code != ATC_DIV_OFF) && ((s_q.pre & div_mask(div_code)) == div_mask(div_code)); // see [R3]
        end
        if (tick)
        begin
            if (s_q.count == top)
            begin
                s_d.count = `ATC_COUNT_RESET; // see [R5]
                s_d.wrap_hit = 1'b1;
                s_d.wrap_event = wstep[2]; // see [R6]
                s_d.wrap_dec = wstep[1:0];
            end
            else
                s_d.count = s_q.count + 16'h0001; // see [R1]
            // a match beyond the top can never fire (see [R18])
            if (s_q.count == match && match <= top)
            begin
                s_d.match_hit = 1'b1; // see [R4]
                s_d.match_event = mstep[2]; // see [R6]
                s_d.match_dec = mstep[1:0];
            end
        end
        if (load_en)
            s_d.count = load_val; // see [R8]
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign count = s_q.count;
    assign match_hit = s_q.match_hit;
    assign wrap_hit = s_q.wrap_hit;
    assign match_event = s_q.match_event;
    assign wrap_event = s_q.wrap_event;

    property p_wrap_zero;
        @(posedge clock) disable iff (!arst_n)
        tick && !load_en && s_q.count == top |=> s_q.count == 16'h0000 && s_q.wrap_hit;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap at top"); // see [R5]

    property p_step_one;
        @(posedge clock) disable iff (!arst_n)
        tick && !load_en && s_q.count != top |=> s_q.count == $past(s_q.count) + 16'h0001;
    endproperty
    a_step_one: assert property (p_step_one) else $error("count did not step by one"); // see [R1]

    property p_off_stops;
        @(posedge clock) disable iff (!arst_n)
        div_code == ATC_DIV_OFF && !load_en |=> $stable(s_q.count) && !s_q.wrap_hit;
    endproperty
    a_off_stops: assert property (p_off_stops) else $error("counter moved while stopped"); // see [R3]

    property p_match_fires;
        @(posedge clock) disable iff (!arst_n)
        tick && s_q.count == match && match <= top |=> s_q.match_hit;
    endproperty
    a_match_fires: assert property (p_match_fires) else $error("compare match missed"); // see [R4]

    property p_match_beyond_top;
        @(posedge clock) disable iff (!arst_n)
        match > top |=> !s_q.match_hit;
    endproperty
    a_match_beyond_top: assert property (p_match_beyond_top) else $error("match fired above top"); // see [R18]

    property p_event_every_hit;
        @(posedge clock) disable iff (!arst_n)
        s_q.wrap_hit && $past(top) >= 16'h0002 |-> s_q.wrap_event;
    endproperty
    a_event_every_hit: assert property (p_event_every_hit) else $error("wrap event dropped"); // see [R6]

endmodule

`default_nettype wire

// *** design/atc_top.sv ***
// async tick counter: AHB-Lite register slave, update synchronisation, flags and requests
`timescale 1ns/1ns
`default_nettype none
`include "atc_params.svh"

// Contract
// [R1] the 16-bit count steps by one on each prescaled reference rising edge
// [R2] a 10-bit prescaler divides the reference before the counter
// [R3] divider code 0 stops counting; codes 1..7 divide by 1,2,8,16,64,256,1024
// [R4] compare request or event on the first count after count equals match
// [R5] wrap request or event after count equals top; the wrap clears the count
// [R6] events thinned to every third at top 0, every second at top 1
// [R7] sync-pending status is set during domain crossing and self-clears when done
// [R8] a count write reaches the counter two reference cycles later
// [R9] software checks sync-pending is clear before writing the count
// [R10] match level field enables the compare request, asserted while match flag set
// [R11] wrap level field enables the wrap request, asserted while wrap flag set
// [R12] match flag sets after a compare; cleared by vector or writing one
// [R13] wrap flag sets after a wrap; cleared by vector or writing one
// [R14] low byte writes go to the stage; low byte reads stage the high byte
// [R15] software writes zeros to reserved bit positions
// [R16] the counter keeps running in sleep and can wake or interrupt
// [R17] counting runs from the reference; updates pass a synchronisation delay
// [R18] no compare match is ever produced while match exceeds top
// [R19] top resets to all ones so the counter wraps at full range
// [R20] bus writes cross by request and acknowledge driving sync-pending
// [R21] reserved and read-only bits ignore writes and read as zero
module atc_top
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        ref_clk_in,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        match_vec_ack,
    input  wire logic        wrap_vec_ack,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             match_irq_req,
    output logic      [1:0]  match_irq_level,
    output logic             wrap_irq_req,
    output logic      [1:0]  wrap_irq_level,
    output logic             match_event,
    output logic             wrap_event
);
    import atc_pkg::*;

    atc_top_state_t s_q;
    atc_top_state_t s_d;

    logic        ref_rise;
    logic        addr_ok;
    logic [3:0]  a_idx;
    logic        a_mapped;
    logic        wr_now;
    logic        wr_sync;
    logic        apply;
    logic [7:0]  wbyte;
    logic [15:0] core_count;
    logic        core_match_hit;
    logic        core_wrap_hit;
    logic [1:0]  flag_clr;
    logic [1:0]  flag_set;

    // registers live in a 64-byte window; anything above reads zero
    function automatic logic idx_mapped(input logic [31:0] a);
        logic [3:0] i;
        i = a[5:2];
        if (a[31:6] != 26'h000_0000)
            idx_mapped = 1'b0;
        else if (i <= `ATC_IDX_BYTE_STAGE)
            idx_mapped = 1'b1;
        else if (i >= `ATC_IDX_COUNT_LOW && i <= `ATC_IDX_MATCH_HIGH)
            idx_mapped = 1'b1;
        else
            idx_mapped = 1'b0;
    endfunction

    // the reference is a synchronous input; one flop gives its rising edge
    assign ref_rise = ref_clk_in & ~s_q.ref_q; // see [R17]

    assign addr_ok = hsel && htrans[1] && hready;
    assign a_idx = haddr[5:2];
    assign a_mapped = idx_mapped(haddr);
    assign wr_now = s_q.dp_write && s_q.dp_mapped;
    assign wbyte = hwdata[7:0];

    always_comb
    begin
        wr_sync = 1'b0;
        if (wr_now)
        begin
            if (s_q.dp_idx == `ATC_IDX_DIVIDER_CONTROL)
                wr_sync = 1'b1;
            else if (s_q.dp_idx == `ATC_IDX_COUNT_HIGH)
                wr_sync = 1'b1;
            else if (s_q.dp_idx == `ATC_IDX_TOP_HIGH)
                wr_sync = 1'b1;
            else if (s_q.dp_idx == `ATC_IDX_MATCH_HIGH)
                wr_sync = 1'b1;
        end
    end

    // the staged values reach the counter on the second reference edge
    assign apply = (s_q.sync == ATC_SYNC_WAIT1) && ref_rise && !wr_sync; // see [R8]

    assign flag_set = {core_match_hit, core_wrap_hit};

    always_comb
    begin
        flag_clr = 2'b00;
        if (wr_now && s_q.dp_idx == `ATC_IDX_IRQ_FLAG_BITS)
            flag_clr = wbyte[1:0];
        flag_clr[`ATC_MATCH_FLAG_BIT] = flag_clr[`ATC_MATCH_FLAG_BIT] | match_vec_ack;
        flag_clr[`ATC_WRAP_FLAG_BIT] = flag_clr[`ATC_WRAP_FLAG_BIT] | wrap_vec_ack;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.ref_q = ref_clk_in;
        s_d.hreadyout = 1'b1;

        // data phase: writes land now, hwdata is valid in this cycle
        if (wr_now)
        begin
            if (s_q.dp_idx == `ATC_IDX_DIVIDER_CONTROL)
                s_d.div_stage = atc_div_t'(wbyte[`ATC_DIV_MSB:0]); // see [R21]
            else if (s_q.dp_idx == `ATC_IDX_IRQ_LEVEL_CTRL)
                s_d.lvl = wbyte[3:0];
            else if (s_q.dp_idx == `ATC_IDX_BYTE_STAGE)
                s_d.stage = wbyte;
            else if (s_q.dp_idx == `ATC_IDX_COUNT_LOW || s_q.dp_idx == `ATC_IDX_TOP_LOW
                     || s_q.dp_idx == `ATC_IDX_MATCH_LOW)
                s_d.stage = wbyte; // see [R14]
            else if (s_q.dp_idx == `ATC_IDX_COUNT_HIGH)
            begin
                s_d.count_stage = {wbyte, s_q.stage}; // see [R14]
                s_d.count_wr = 1'b1;
            end
            else if (s_q.dp_idx == `ATC_IDX_TOP_HIGH)
                s_d.top_stage = {wbyte, s_q.stage};
            else if (s_q.dp_idx == `ATC_IDX_MATCH_HIGH)
                s_d.match_stage = {wbyte, s_q.stage};
        end

        // crossing handshake: a write requests, the second reference edge acknowledges
        case (s_q.sync)
            ATC_SYNC_IDLE:
            begin
                if (wr_sync)
                    s_d.sync = ATC_SYNC_WAIT0; // see [R20]
            end
            ATC_SYNC_WAIT0:
            begin
                if (wr_sync)
                    s_d.sync = ATC_SYNC_WAIT0;
                else if (ref_rise)
                    s_d.sync = ATC_SYNC_WAIT1;
            end
            ATC_SYNC_WAIT1:
            begin
                // a fresh write restarts the crossing so no update is lost
                if (wr_sync)
                    s_d.sync = ATC_SYNC_WAIT0;
                else if (ref_rise)
                    s_d.sync = ATC_SYNC_IDLE; // see [R7]
            end
            default:
                s_d.sync = ATC_SYNC_IDLE;
        endcase

        if (apply)
        begin
            s_d.div_act = s_q.div_stage; // see [R17]
            s_d.top_act = s_q.top_stage;
            s_d.match_act = s_q.match_stage;
            s_d.count_wr = 1'b0;
        end

        // a hardware set in the same cycle beats any clear
        s_d.flags = (s_q.flags & ~flag_clr) | flag_set; // see [R12] see [R13]
        s_d.match_irq = s_d.flags[`ATC_MATCH_FLAG_BIT]
                        && (s_d.lvl[`ATC_MATCH_LVL_MSB:`ATC_MATCH_LVL_LSB] != 2'h0); // see [R10]
        s_d.wrap_irq = s_d.flags[`ATC_WRAP_FLAG_BIT]
                       && (s_d.lvl[`ATC_WRAP_LVL_MSB:`ATC_WRAP_LVL_LSB] != 2'h0); // see [R11]

        // address phase: capture the transfer and prepare read data for the data phase
        s_d.dp_write = 1'b0;
        s_d.dp_mapped = 1'b0;
        if (addr_ok)
        begin
            s_d.dp_write = hwrite;
            s_d.dp_idx = a_idx;
            s_d.dp_mapped = a_mapped;
            s_d.hrdata = 32'h0000_0000;
            if (!hwrite && a_mapped)
            begin
                if (a_idx == `ATC_IDX_DIVIDER_CONTROL)
                    s_d.hrdata[`ATC_DIV_MSB:0] = s_q.div_stage;
                else if (a_idx == `ATC_IDX_SYNC_STATUS)
                    s_d.hrdata[`ATC_PENDING_BIT] = (s_q.sync != ATC_SYNC_IDLE); // see [R7]
                else if (a_idx == `ATC_IDX_IRQ_LEVEL_CTRL)
                    s_d.hrdata[3:0] = s_q.lvl;
                else if (a_idx == `ATC_IDX_IRQ_FLAG_BITS)
                    s_d.hrdata[1:0] = s_q.flags;
                else if (a_idx == `ATC_IDX_BYTE_STAGE)
                    s_d.hrdata[7:0] = s_q.stage;
                else if (a_idx == `ATC_IDX_COUNT_LOW)
                begin
                    s_d.hrdata[7:0] = core_count[7:0];
                    s_d.stage = core_count[15:8]; // see [R14]
                end
                else if (a_idx == `ATC_IDX_TOP_LOW)
                begin
                    s_d.hrdata[7:0] = s_q.top_stage[7:0];
                    s_d.stage = s_q.top_stage[15:8];
                end
                else if (a_idx == `ATC_IDX_MATCH_LOW)
                begin
                    s_d.hrdata[7:0] = s_q.match_stage[7:0];
                    s_d.stage = s_q.match_stage[15:8];
                end
                else
                    s_d.hrdata[7:0] = s_q.stage;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.top_stage <= `ATC_TOP_RESET; // see [R19]
            s_q.top_act <= `ATC_TOP_RESET;
            s_q.match_stage <= `ATC_MATCH_RESET;
            s_q.match_act <= `ATC_MATCH_RESET;
            s_q.div_stage <= ATC_DIV_OFF;
            s_q.div_act <= ATC_DIV_OFF;
            s_q.sync <= ATC_SYNC_IDLE;
        end
        else
            s_q <= s_d;
    end

    atc_core u_core
    (
        .clock      (clock),
        .arst_n     (arst_n),
        .ref_rise   (ref_rise),
        .div_code   (s_q.div_act),
        .top        (s_q.top_act),
        .match      (s_q.match_act),
        .load_en    (apply && s_q.count_wr),
        .load_val   (s_q.count_stage),
        .count      (core_count),
        .match_hit  (core_match_hit),
        .wrap_hit   (core_wrap_hit),
        .match_event(match_event),
        .wrap_event (wrap_event)
    );

    assign hrdata = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp = 1'b0;
    assign match_irq_req = s_q.match_irq;
    assign wrap_irq_req = s_q.wrap_irq;
    assign match_irq_level = s_q.lvl[`ATC_MATCH_LVL_MSB:`ATC_MATCH_LVL_LSB];
    assign wrap_irq_level = s_q.lvl[`ATC_WRAP_LVL_MSB:`ATC_WRAP_LVL_LSB];

    property p_pending_on_write;
        @(posedge clock) disable iff (!arst_n)
        wr_sync |=> s_q.sync == ATC_SYNC_WAIT0;
    endproperty
    a_pending_on_write: assert property (p_pending_on_write) else $error("sync pending not raised"); // see [R7]

    property p_count_load;
        @(posedge clock) disable iff (!arst_n)
        apply && s_q.count_wr |=> core_count == $past(s_q.count_stage) && s_q.sync == ATC_SYNC_IDLE;
    endproperty
    a_count_load: assert property (p_count_load) else $error("count write not applied"); // see [R8]

    property p_match_flag_set;
        @(posedge clock) disable iff (!arst_n)
        core_match_hit |=> s_q.flags[1];
    endproperty
    a_match_flag_set: assert property (p_match_flag_set) else $error("match flag not set"); // see [R12]

    property p_wrap_flag_set;
        @(posedge clock) disable iff (!arst_n)
        core_wrap_hit |=> s_q.flags[0];
    endproperty
    a_wrap_flag_set: assert property (p_wrap_flag_set) else $error("wrap flag not set"); // see [R13]

    property p_match_req;
        @(posedge clock) disable iff (!arst_n)
        match_irq_req == (s_q.flags[1] && match_irq_level != 2'h0);
    endproperty
    a_match_req: assert property (p_match_req) else $error("match request mismatch"); // see [R10]

    property p_wrap_req;
        @(posedge clock) disable iff (!arst_n)
        wrap_irq_req == (s_q.flags[0] && wrap_irq_level != 2'h0);
    endproperty
    a_wrap_req: assert property (p_wrap_req) else $error("wrap request mismatch"); // see [R11]

    property p_low_read_stages;
        @(posedge clock) disable iff (!arst_n)
        addr_ok && !hwrite && a_mapped && a_idx == `ATC_IDX_COUNT_LOW |=> s_q.stage == $past(core_count[15:8]);
    endproperty
    a_low_read_stages: assert property (p_low_read_stages) else $error("high byte not staged"); // see [R14]

endmodule

`default_nettype wire

// *** verification/atc_cpu_model.sv ***
// cpu side model: runs an interrupt vector for each enabled request
`timescale 1ns/1ns
`default_nettype none
module atc_cpu_model
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic ack_en,
    input  wire logic match_irq_req,
    input  wire logic wrap_irq_req,
    output logic      match_vec_ack,
    output logic      wrap_vec_ack
);
    // a repeat pulse while the request falls is harmless, it only clears again
    always_ff @(posedge clock or negedge arst_n)
        if (!arst_n)
        begin
            match_vec_ack <= 1'h0;
            wrap_vec_ack  <= 1'h0;
        end
        else
        begin
            match_vec_ack <= ack_en & match_irq_req & ~match_vec_ack;
            wrap_vec_ack  <= ack_en & wrap_irq_req & ~wrap_vec_ack;
        end
endmodule
`default_nettype wire

// *** verification/async_tick_counter_test.sv ***
// register level bench of the tick counter
`timescale 1ns/1ns
`default_nettype none
module async_tick_counter_test;
    logic        clock = 1'h0;
    logic        arst_n = 1'h0;
    logic        ref_clk_in = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic        ack_en = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [7:0]  c0;
    logic [1:0]  match_irq_level;
    logic [1:0]  wrap_irq_level;
    logic        hreadyout, hresp, match_irq_req, wrap_irq_req;
    logic        match_event, wrap_event, match_vec_ack, wrap_vec_ack;
    wire logic   hready;
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n;

    assign hready = hreadyout;
    always #50 clock = ~clock;

    atc_top dut_u (.clock(clock), .arst_n(arst_n), .ref_clk_in(ref_clk_in), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .match_vec_ack(match_vec_ack), .wrap_vec_ack(wrap_vec_ack),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .match_irq_req(match_irq_req),
        .match_irq_level(match_irq_level), .wrap_irq_req(wrap_irq_req),
        .wrap_irq_level(wrap_irq_level), .match_event(match_event), .wrap_event(wrap_event));

    atc_cpu_model cpu_u (.clock(clock), .arst_n(arst_n), .ack_en(ack_en),
        .match_irq_req(match_irq_req), .wrap_irq_req(wrap_irq_req),
        .match_vec_ack(match_vec_ack), .wrap_vec_ack(wrap_vec_ack));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one single transfer; entered right after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'h1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge clock); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        xfer(1'h0, a, 8'h00);
        chk(nm, r[7:0], e);
    endtask

    task automatic settle;
        n = 0;
        do
        begin
            xfer(1'h0, 8'h04, 8'h00);
            n++;
        end
        while (r[0] !== 1'h0 && n < 50);
        chk("sync_status", r[7:0], 8'h00);
    endtask

    task automatic await(ref logic s, input logic v, input string nm);
        n = 0;
        while (s !== v && n < 3000)
        begin
            @(posedge clock);
            n++;
        end
        chk(nm, {7'h00, s}, {7'h00, v});
    endtask

    always @(posedge clock)
    begin
        cyc++;
        // reference period of 14 clocks, slow against the bus so every edge is seen
        if (cyc % 7 == 0)
            ref_clk_in <= ~ref_clk_in;
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end

    initial
    begin
        repeat (4) @(posedge clock);
        arst_n <= 1'h1;
        @(posedge clock);
        rc(8'h00, 8'h00, "divider_control");
        rc(8'h04, 8'h00, "sync_status");
        rc(8'h08, 8'h00, "irq_level_control");
        rc(8'h0c, 8'h00, "irq_flag_bits");
        rc(8'h28, 8'hff, "top_low");
        rc(8'h2c, 8'hff, "top_high");
        rc(8'h18, 8'h00, "unmapped");
        chk("hresp", {7'h00, hresp}, 8'h00);
        xfer(1'h1, 8'h28, 8'h03);
        xfer(1'h1, 8'h2c, 8'h00);
        rc(8'h04, 8'h01, "sync_status");
        settle;
        xfer(1'h1, 8'h30, 8'h01);
        xfer(1'h1, 8'h34, 8'h00);
        settle;
        xfer(1'h1, 8'h08, 8'h05);
        rc(8'h08, 8'h05, "irq_level_control");
        // status is read-only, a written one must not stick
        xfer(1'h1, 8'h04, 8'h01);
        rc(8'h04, 8'h00, "sync_status");
        chk("match_irq_level", {6'h00, match_irq_level}, 8'h01);
        chk("wrap_irq_level", {6'h00, wrap_irq_level}, 8'h01);
        xfer(1'h1, 8'h00, 8'h01);
        settle;
        await(match_irq_req, 1'h1, "match_irq_req");
        await(wrap_irq_req, 1'h1, "wrap_irq_req");
        await(wrap_event, 1'h1, "wrap_event");
        await(match_event, 1'h1, "match_event");
        xfer(1'h1, 8'h00, 8'h00);
        settle;
        rc(8'h0c, 8'h03, "irq_flag_bits");
        xfer(1'h1, 8'h0c, 8'h03);
        rc(8'h0c, 8'h00, "irq_flag_bits");
        xfer(1'h0, 8'h20, 8'h00);
        c0 = r[7:0];
        chk("count_wrapped", {7'h00, c0 <= 8'h03}, 8'h01);
        repeat (100) @(posedge clock);
        rc(8'h20, c0, "count_low");
        xfer(1'h1, 8'h20, 8'h02);
        rc(8'h10, 8'h02, "byte_stage");
        xfer(1'h1, 8'h24, 8'h00);
        settle;
        rc(8'h20, 8'h02, "count_low");
        rc(8'h10, 8'h00, "byte_stage");
        ack_en <= 1'h1;
        xfer(1'h1, 8'h00, 8'h01);
        await(wrap_irq_req, 1'h1, "wrap_irq_req");
        await(wrap_irq_req, 1'h0, "wrap_irq_req");
        // count and top of zero go live together, so every tick wraps
        settle;
        xfer(1'h1, 8'h20, 8'h00);
        xfer(1'h1, 8'h24, 8'h00);
        xfer(1'h1, 8'h28, 8'h00);
        xfer(1'h1, 8'h2c, 8'h00);
        settle;
        // a wrap every 14 clocks, an event on every third: two in 120 clocks
        await(wrap_event, 1'h1, "wrap_event");
        c0 = 8'h00;
        repeat (120)
        begin
            @(posedge clock);
            c0 = c0 + {7'h00, wrap_event};
        end
        chk("wrap_event_count", c0, 8'h02);
        tally_and_finish;
    end
endmodule
`default_nettype wire
